// [rtl/fcds_pkg.sv]
/*
  shared constants and types for the four channel dimming scheduler.
  assumes a single 40 MHz system clock and a plain register port.
*/
package fcds_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000; // system clock rate
  localparam int BASE_US = 1; // tick timer resolution, us
  localparam int CYC_PER_US = (CLK_HZ / 1_000_000) * BASE_US; // cycles per base tick
  localparam int UNIT_US = 20; // schedule unit, us
  localparam int WAKE_US = 100; // settle delay before acquisition, us
  localparam int PERIOD_UNITS = 256; // dimming period in units (5120 us, about 5 ms)
  localparam int QUARTER_UNITS = PERIOD_UNITS / 4; // 90 degree channel lag
  localparam int TAB_LEN = 8; // schedule entries
  localparam int SAMPLES = 4; // samples per voltage
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00; // enable, copy, button request
  localparam logic [7:0] OFS_STAT = 8'h04; // status, w1c flags
  localparam logic [7:0] OFS_ERR = 8'h08; // latched error code
  localparam logic [7:0] OFS_TAB = 8'h10; // staged table, 8 words
  localparam logic [7:0] OFS_TIM = 8'h30; // timing parameters, 4 words
  localparam logic [7:0] OFS_AVG = 8'h40; // averages, 4 words
  localparam logic [7:0] OFS_BTN = 8'h50; // button sample
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EN = 0; // scheduling enable
  localparam int CTRL_COPY = 1; // request staged table copy
  localparam int CTRL_BTN = 2; // request button sample
  localparam int STAT_FAULT = 4; // fault flags, 4 bits
  localparam int STAT_DONE = 8; // conversion done flag
  localparam int STAT_COPY = 9; // copy pending
  localparam int STAT_LIVE = 10; // trip condition present now
  localparam int STAT_PTR = 12; // schedule pointer, 3 bits
  localparam int ACT_ON = 7; // action byte: 1 = switch on
  localparam int AVG_HI = 16; // common-node average position
  localparam logic [2:0] BTN_MUX = 3'h7; // converter input of the buttons
  // ----------------------------------------
  // error codes
  // ----------------------------------------
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_START = 4'h1; // on-action off its fixed start
  localparam logic [3:0] ERR_TRIP = 4'h2; // overcurrent trip
  localparam logic [3:0] ERR_DISCARD = 4'h3; // samples thrown away
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] act; // bit 7 on/off, bits 1:0 channel
    logic [7:0] dly; // units to next event, 0 means 256
  } fcds_entry_s;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_WAIT, ACQ_CONV, ACQ_BTN} fcds_acq_e;
endpackage

// [rtl/fcds_top.sv]
/*
  four channel dimming scheduler: table driven run events, fixed quarter
  lag starts, overcurrent stop, delayed averaged voltage acquisition,
  deferred engine parameter and table updates.
  assumes engines and converter handshake sit outside; trip inputs are
  asynchronous, converter done/data are on clk.
*/
// Functional notes
// - period repeats about every 5 ms
// - on: drive channel run event active
// - on-time over: run event off till next cycle
// - each channel starts a quarter period later
// - start instants fixed, only on-time varies
// - on-time counted in 20 us units
// - eight two-byte schedule entries
// - timer reloaded with next entry delay
// - switch-on requests delayed acquisition
// - engine trips only from fault zone
// - trip clears run event, sets fault
// - tripped channel restarts next cycle
// - acquisition starts 100 us after start
// - four samples each voltage, averaged
// - discard samples if channel already off
// - completion sets conversion done flag
// - engine timing loaded only while stopped
// - staged table copied as entry 7 fires
// - serial service ranks lowest
// - trip detection left to engine hardware
// - button sampling never overlaps acquisition
// - error code latched, monitoring continues
// - run event high resumes paused engine
`timescale 1ns/10ps
module fcds_top
  import fcds_pkg::*;
#(
  parameter int ADC_W = 10, // converter data width
  parameter int TW = 16 // engine timing word width
)
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic [3:0] run_event, // channel_run_event per engine
  input wire logic [3:0] trip_in, // overcurrent_trip from engines
  output logic [3:0][TW-1:0] eng_param, // engine timing words
  output logic [3:0] eng_load, // engine load pulse
  output logic adc_start, // converter start pulse
  output logic [2:0] adc_mux, // converter input select
  input wire logic adc_done, // converter result valid
  input wire logic [ADC_W-1:0] adc_data, // converter result
  input wire logic [1:0] serial_req, // serial rx/tx service requests
  output logic [5:0] service_grant, // one-hot granted service
  output logic fault_led // fault indicator drive
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  // delay byte to unit count, zero means 256
  function automatic logic [8:0] dly_units(input logic [7:0] d);
    dly_units = (d == 8'h00) ? 9'h100 : {1'b0, d};
  endfunction
  // lowest set bit of a 4-bit request
  function automatic logic [1:0] low_idx(input logic [3:0] r);
    low_idx = r[0] ? 2'h0 : r[1] ? 2'h1 : r[2] ? 2'h2 : 2'h3;
  endfunction
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [5:0] US_LAST = 6'(CYC_PER_US - 1); // base prescale end
  localparam logic [4:0] UNIT_LAST = 5'(UNIT_US - 1); // unit prescale end
  localparam logic [6:0] WAKE_CNT = 7'(WAKE_US / BASE_US); // settle ticks
  localparam logic [7:0] QTR = 8'(QUARTER_UNITS); // quarter in units
  logic rst_ff1_reg, rst_sync_b; // reset synchroniser
  logic [3:0] trip_meta_reg, trip_sync_reg, trip_prev_reg; // trip sync
  logic [3:0] trip_edge; // trip arrival
  logic en_reg; // scheduling enabled
  logic [5:0] us_cnt_reg; // base tick prescaler
  logic [4:0] unit_cnt_reg; // unit prescaler
  logic us_tick, unit_tick; // enable pulses
  logic [8:0] dly_reg; // units left to next event
  logic [2:0] ptr_reg; // schedule pointer
  logic [7:0] pos_reg; // position in period, units
  logic fire; // schedule event now
  fcds_entry_s cur; // entry being executed
  fcds_entry_s act_tab [TAB_LEN]; // active table
  fcds_entry_s stg_tab [TAB_LEN]; // staged table
  logic copy_pend_reg; // staged copy waiting
  logic start_ok; // on-action sits on its fixed start
  logic on_go; // accepted switch-on
  logic [3:0] fault_reg; // sticky fault flags
  logic [3:0] acq_pend_reg; // acquisition requests
  fcds_acq_e acq_reg; // acquisition state
  logic [1:0] acq_ch_reg; // channel under acquisition
  logic [6:0] wk_reg; // wakeup countdown
  logic [2:0] idx_reg; // sample index
  logic [ADC_W+1:0] sum_v_reg, sum_c_reg; // sample sums
  logic [3:0][ADC_W-1:0] avg_v_reg, avg_c_reg; // stored averages
  logic [ADC_W-1:0] btn_reg; // button sample
  logic btn_req_reg; // button sample wanted
  logic done_reg; // conversion_done_flag
  logic acq_end; // last sample arrives
  logic wake_end; // wakeup delay expired
  logic [3:0] err_reg; // latched error code
  logic [3:0] err_now; // error raised this cycle
  logic [3:0] tim_pend_reg; // timing_update_request bits
  logic [3:0][TW-1:0] tim_next_reg; // recomputed timing words
  logic wr_ctrl, wr_stat; // decoded writes
  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  // release reset through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_ff1_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_ff1_reg <= 1'b1;
      rst_sync_b <= rst_ff1_reg;
    end
  end
  // trip inputs come from faster engine logic
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      trip_meta_reg <= 4'h0;
      trip_sync_reg <= 4'h0;
      trip_prev_reg <= 4'h0;
    end
    else
    begin
      trip_meta_reg <= trip_in;
      trip_sync_reg <= trip_meta_reg;
      trip_prev_reg <= trip_sync_reg;
    end
  end
  // engine raises trip on leaving its hold state; detection stays in engine
  assign trip_edge = trip_sync_reg & ~trip_prev_reg;
  // ----------------------------------------
  // tick timer and schedule walk
  // ----------------------------------------
  assign us_tick = (us_cnt_reg == US_LAST);
  assign unit_tick = us_tick && (unit_cnt_reg == UNIT_LAST);
  // base and unit prescalers, free while enabled
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      us_cnt_reg <= 6'h00;
      unit_cnt_reg <= 5'h00;
    end
    else if (!en_reg || dly_reg == 9'h000) // restart fire aligns units to entry zero
    begin
      us_cnt_reg <= 6'h00;
      unit_cnt_reg <= 5'h00;
    end
    else
    begin
      us_cnt_reg <= us_tick ? 6'h00 : us_cnt_reg + 6'h01;
      if (us_tick)
        unit_cnt_reg <= (unit_cnt_reg == UNIT_LAST) ? 5'h00 : unit_cnt_reg + 5'h01;
    end
  end
  assign cur = act_tab[ptr_reg];
  assign fire = en_reg && ((dly_reg == 9'h000) || (unit_tick && dly_reg == 9'h001));
  // reload with next entry delay and step the pointer
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      dly_reg <= 9'h000;
      ptr_reg <= 3'h0;
      pos_reg <= 8'h00;
    end
    else if (!en_reg)
    begin
      dly_reg <= 9'h000;
      ptr_reg <= 3'h0;
      pos_reg <= 8'h00;
    end
    else
    begin
      if (fire)
      begin
        dly_reg <= dly_units(cur.dly);
        ptr_reg <= ptr_reg + 3'h1;
      end
      else if (unit_tick)
        dly_reg <= dly_reg - 9'h001;
      // position restarts with entry zero, period repeats
      if (fire && ptr_reg == 3'h0)
        pos_reg <= 8'h00;
      else if (unit_tick)
        pos_reg <= pos_reg + 8'h01;
    end
  end
  // start instants fixed at channel times a quarter period
  // a fire on a unit tick already sits at the next position
  assign start_ok = ((ptr_reg == 3'h0) ? 8'h00 : pos_reg + {7'h00, unit_tick}) ==
                    QTR * {6'h00, cur.act[1:0]};
  assign on_go = fire && cur.act[ACT_ON] && start_ok;
  // run events: on, off, trip stop
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      run_event <= 4'h0;
    else if (!en_reg)
      run_event <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (trip_edge[i])
          run_event[i] <= 1'b0;
        else if (on_go && cur.act[1:0] == 2'(i))
          run_event[i] <= 1'b1;
        else if (fire && !cur.act[ACT_ON] && cur.act[1:0] == 2'(i))
          run_event[i] <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // tables
  // ----------------------------------------
  // staged entries written by software
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      for (int i = 0; i < TAB_LEN; i++)
        stg_tab[i] <= '0;
    end
    else if (wr && addr >= OFS_TAB && addr < OFS_TIM && addr[1:0] == 2'h0)
      stg_tab[addr[4:2] - 3'h4] <= wdata[15:0];
  end
  // copy when entry 7 fires or while disabled, before entry zero runs
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      copy_pend_reg <= 1'b0;
      for (int i = 0; i < TAB_LEN; i++)
        act_tab[i] <= '0;
    end
    else if (copy_pend_reg && (!en_reg || (fire && ptr_reg == 3'h7)))
    begin
      copy_pend_reg <= wr_ctrl && wdata[CTRL_COPY];
      for (int i = 0; i < TAB_LEN; i++)
        act_tab[i] <= stg_tab[i];
    end
    else if (wr_ctrl && wdata[CTRL_COPY])
      copy_pend_reg <= 1'b1;
  end
  // ----------------------------------------
  // faults and errors
  // ----------------------------------------
  // sticky faults, a new trip wins over a clear
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      fault_reg <= 4'h0;
    else
      fault_reg <= trip_edge | (fault_reg & ~(wr_stat ? wdata[STAT_FAULT+:4] : 4'h0));
  end
  assign fault_led = |fault_reg;
  assign err_now = (fire && cur.act[ACT_ON] && !start_ok) ? ERR_START :
                   (|trip_edge) ? ERR_TRIP :
                   (acq_end && !run_event[acq_ch_reg]) ? ERR_DISCARD : ERR_NONE;
  // first error held until software clears it
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      err_reg <= ERR_NONE;
    else if (err_now != ERR_NONE && (err_reg == ERR_NONE || (wr && addr == OFS_ERR)))
      err_reg <= err_now;
    else if (wr && addr == OFS_ERR)
      err_reg <= ERR_NONE;
  end
  // ----------------------------------------
  // delayed voltage acquisition
  // ----------------------------------------
  assign wake_end = (acq_reg == ACQ_WAIT) && us_tick && (wk_reg == 7'h01);
  assign acq_end = (acq_reg == ACQ_CONV) && adc_done && (idx_reg == 3'(2 * SAMPLES - 1));
  // requests raised at each switch-on, cleared when taken
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      acq_pend_reg <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (on_go && cur.act[1:0] == 2'(i))
          acq_pend_reg[i] <= 1'b1;
        else if (acq_reg == ACQ_IDLE && |acq_pend_reg && low_idx(acq_pend_reg) == 2'(i))
          acq_pend_reg[i] <= 1'b0;
      end
    end
  end
  // acquisition sequencer; button only when no channel waits
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      acq_reg <= ACQ_IDLE;
      acq_ch_reg <= 2'h0;
      wk_reg <= 7'h00;
      idx_reg <= 3'h0;
      adc_start <= 1'b0;
      adc_mux <= 3'h0;
    end
    else
    begin
      adc_start <= 1'b0;
      case (acq_reg)
        ACQ_IDLE:
        begin
          if (|acq_pend_reg)
          begin
            acq_ch_reg <= low_idx(acq_pend_reg);
            wk_reg <= WAKE_CNT;
            acq_reg <= ACQ_WAIT;
          end
          else if (btn_req_reg)
          begin
            adc_mux <= BTN_MUX;
            adc_start <= 1'b1;
            acq_reg <= ACQ_BTN;
          end
        end
        ACQ_WAIT:
        begin
          if (us_tick)
            wk_reg <= wk_reg - 7'h01;
          if (wake_end)
          begin
            idx_reg <= 3'h0;
            adc_mux <= {acq_ch_reg, 1'b0};
            adc_start <= 1'b1;
            acq_reg <= ACQ_CONV;
          end
        end
        ACQ_CONV:
        begin
          if (adc_done)
          begin
            idx_reg <= idx_reg + 3'h1;
            if (acq_end)
              acq_reg <= ACQ_IDLE;
            else
            begin
              adc_mux <= {acq_ch_reg, ~idx_reg[0]};
              adc_start <= 1'b1;
            end
          end
        end
        ACQ_BTN:
        begin
          if (adc_done)
            acq_reg <= ACQ_IDLE;
        end
        default: acq_reg <= ACQ_IDLE;
      endcase
    end
  end
  // sums, averages and button result
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      sum_v_reg <= '0;
      sum_c_reg <= '0;
      avg_v_reg <= '0;
      avg_c_reg <= '0;
      btn_reg <= '0;
    end
    else if (acq_reg == ACQ_WAIT)
    begin
      sum_v_reg <= '0;
      sum_c_reg <= '0;
    end
    else if (acq_reg == ACQ_CONV && adc_done)
    begin
      if (idx_reg[0])
        sum_c_reg <= sum_c_reg + {2'b00, adc_data};
      else
        sum_v_reg <= sum_v_reg + {2'b00, adc_data};
      // store only if the channel still runs
      if (acq_end && run_event[acq_ch_reg])
      begin
        avg_v_reg[acq_ch_reg] <= sum_v_reg[ADC_W+1:2];
        avg_c_reg[acq_ch_reg] <= ADC_W'((sum_c_reg + {2'b00, adc_data}) >> 2);
      end
    end
    else if (acq_reg == ACQ_BTN && adc_done)
      btn_reg <= adc_data;
  end
  // done flag and button request, set wins over clear
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      done_reg <= 1'b0;
      btn_req_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (acq_end && run_event[acq_ch_reg]) ||
                  (done_reg && !(wr_stat && wdata[STAT_DONE]));
      btn_req_reg <= (wr_ctrl && wdata[CTRL_BTN]) || (btn_req_reg && acq_reg != ACQ_BTN);
    end
  end
  // ----------------------------------------
  // engine timing update
  // ----------------------------------------
  // load new words only while the run event is low
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      tim_pend_reg <= 4'h0;
      tim_next_reg <= '0;
      eng_param <= '0;
      eng_load <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        eng_load[i] <= 1'b0;
        if (wr && addr == OFS_TIM + 8'(4 * i))
        begin
          tim_next_reg[i] <= wdata[TW-1:0];
          tim_pend_reg[i] <= 1'b1;
        end
        else if (tim_pend_reg[i] && !run_event[i])
        begin
          eng_param[i] <= tim_next_reg[i];
          eng_load[i] <= 1'b1;
          tim_pend_reg[i] <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // service ranking
  // ----------------------------------------
  // tick, wakeup, engine, converter ahead of serial rx, tx
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      service_grant <= 6'h00;
    else if (fire)
      service_grant <= 6'h01;
    else if (wake_end)
      service_grant <= 6'h02;
    else if (|trip_edge)
      service_grant <= 6'h04;
    else if (acq_end)
      service_grant <= 6'h08;
    else if (serial_req[0])
      service_grant <= 6'h10;
    else if (serial_req[1])
      service_grant <= 6'h20;
    else
      service_grant <= 6'h00;
  end
  // ----------------------------------------
  // register port
  // ----------------------------------------
  assign wr_ctrl = wr && addr == OFS_CTRL;
  assign wr_stat = wr && addr == OFS_STAT;
  // enable bit steers the scheduler
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      en_reg <= 1'b0;
    else if (wr_ctrl)
      en_reg <= wdata[CTRL_EN];
  end
  // read data valid the cycle after rd
  always_ff @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      rdata <= 32'h0000_0000;
      if (addr == OFS_CTRL)
        rdata[CTRL_EN] <= en_reg;
      else if (addr == OFS_STAT)
        rdata <= {17'h0, ptr_reg, 1'b0, |trip_sync_reg, copy_pend_reg, done_reg, fault_reg, run_event};
      else if (addr == OFS_ERR)
        rdata[3:0] <= err_reg;
      else if (addr >= OFS_TAB && addr < OFS_TIM && addr[1:0] == 2'h0)
        rdata[15:0] <= stg_tab[addr[4:2] - 3'h4];
      else if (addr >= OFS_TIM && addr < OFS_AVG && addr[1:0] == 2'h0)
        rdata[TW-1:0] <= tim_next_reg[addr[3:2]];
      else if (addr >= OFS_AVG && addr < OFS_BTN && addr[1:0] == 2'h0)
      begin
        rdata[ADC_W-1:0] <= avg_v_reg[addr[3:2]];
        rdata[AVG_HI+:ADC_W] <= avg_c_reg[addr[3:2]];
      end
      else if (addr == OFS_BTN)
        rdata[ADC_W-1:0] <= btn_reg;
    end
  end
endmodule

// [verif/fcds_partner.sv]
/*
  far side model: engine trip lines and the shared converter.
  assumes one clock; a conversion ends five cycles after its start.
*/
`timescale 1ns/10ps
module fcds_partner (
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic adc_start, // conversion start
  input wire logic [2:0] adc_mux, // input select
  input wire logic [3:0] run_event, // engine run levels
  input wire logic [3:0] oc_req, // injected overcurrent
  output logic adc_done, // result strobe
  output logic [9:0] adc_data, // result, inverted while idle
  output logic [3:0] trip_in // engine trip lines
);
  logic [2:0] busy_reg; // conversion countdown
  logic [2:0] mux_reg; // latched input
  logic [5:0] n_reg; // conversions so far
  // converter result encodes input and sample number
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {busy_reg, mux_reg, n_reg, adc_done, adc_data, trip_in} <= '0;
    else
    begin
      busy_reg <= adc_start ? 3'h4 : busy_reg - 3'(busy_reg != 3'h0);
      mux_reg <= adc_start ? adc_mux : mux_reg;
      adc_done <= (busy_reg == 3'h1);
      n_reg <= n_reg + 6'(busy_reg == 3'h1);
      adc_data <= (busy_reg == 3'h1) ? {1'b0, mux_reg, n_reg} : ~adc_data;
      // trips only from a running engine, line held while the fault stays
      trip_in <= oc_req & (run_event | trip_in);
    end
endmodule

// [verif/fcds_top_chk.sv]
/*
  port checker for the dimming scheduler, bound into its top.
  assumes one clock and rst_b low during reset.
*/
`timescale 1ns/10ps
module fcds_top_chk
  import fcds_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic [3:0] run_event, // run events
  input wire logic [3:0] trip_in, // trips
  input wire logic [3:0] eng_load, // loads
  input wire logic adc_start, // start
  input wire logic [2:0] adc_mux, // select
  input wire logic [5:0] service_grant, // grant
  input wire logic fault_led // lamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] run_reg; // last run events
  logic [12:0] wake_reg = 13'h1FFF; // cycles since channel 0 start
  // settle count for channel 0
  always_ff @(posedge clk)
  begin
    run_reg <= run_event;
    if (run_event[0] && !run_reg[0])
      wake_reg <= 13'h0000;
    else if (wake_reg != 13'h1FFF)
      wake_reg <= wake_reg + 13'h0001;
  end
  property p_idle; $rose(rst_b) |-> run_event == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("run after reset");
  property p_lag; $onehot0(run_event & ~run_reg); endproperty
  a_lag: assert property (p_lag) else $error("starts together");
  property p_alt; adc_start && adc_mux != BTN_MUX && !adc_mux[0] |-> ##[2:60] adc_start && adc_mux[0]; endproperty
  a_alt: assert property (p_alt) else $error("no common sample");
  property p_wake; adc_start && adc_mux == 3'h0 |-> wake_reg inside {[13'd3900:13'd4100]}; endproperty
  a_wake: assert property (p_wake) else $error("settle time");
  property p_load; (eng_load & $past(run_event)) == 4'h0; endproperty
  a_load: assert property (p_load) else $error("load while on");
  property p_trip; |(trip_in & ~$past(trip_in)) |-> ##[2:6] (run_event & trip_in) == 4'h0; endproperty
  a_trip: assert property (p_trip) else $error("run after trip");
  property p_led; |(trip_in & ~$past(trip_in)) |-> ##[2:6] fault_led; endproperty
  a_led: assert property (p_led) else $error("no fault lamp");
  property p_grant; $onehot0(service_grant); endproperty
  a_grant: assert property (p_grant) else $error("two grants");
  c_on: cover property (run_event[0] && !run_reg[0]);
  c_trip: cover property (fault_led);
  c_acq: cover property (adc_start && adc_mux[0]);
endmodule
bind fcds_top fcds_top_chk u_chk (.*);

// [verif/fcds_top_test.sv]
/*
  bench of the dimming scheduler: start timing, lag, trip stop,
  averaging, discard and deferred timing load.
  assumes the partner model for converter and engines.
*/
`timescale 1ns/10ps
module fcds_top_test
  import fcds_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0; // clock, reset, strobes
  logic [7:0] addr = 8'h00; // register address
  logic [31:0] wdata = 32'h0, rdata, d; // bus data, last read
  logic [3:0] run_event, trip_in, eng_load, run_last = 4'h0; // channel lines
  logic [3:0] oc_req = 4'h0; // injected overcurrent
  logic [3:0][15:0] eng_param; // timing words
  logic adc_start, adc_done, fault_led; // converter, lamp
  logic [2:0] adc_mux; // converter select
  logic [9:0] adc_data; // converter result
  logic [1:0] serial_req = 2'h3; // serial always asking
  logic [5:0] service_grant; // grant
  logic [7:0] on_u [4] = '{8'h08, 8'h04, 8'h10, 8'h10}; // on-times in units
  int n_errors = 0, n_checks = 0, cyc = 0; // counters
  int t_on [4], t_off [4]; // run edge cycles
  fcds_top dut (.*);
  fcds_partner far (.*);
  always #12.5 clk = ~clk;
  // run edge times and hang guard
  always @(posedge clk)
  begin
    cyc++;
    for (int i = 0; i < 4; i++)
    begin
      if (run_event[i] && !run_last[i]) t_on[i] = cyc;
      if (!run_event[i] && run_last[i]) t_off[i] = cyc;
    end
    run_last = run_event;
    if (cyc == 80000)
    begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_reset;
    chk("run_event", 32'h0, {28'h0, run_event});
    rd_reg(OFS_STAT);
    chk("status", 32'h0, d);
    rd_reg(8'hFC);
    chk("unmapped", 32'h0, d);
    // button sample while idle, takes converter count 0
    wr_reg(OFS_CTRL, 32'h4);
    repeat (8) @(posedge clk);
    rd_reg(OFS_BTN);
    chk("button", 32'h1C0, d);
    chk("service_grant", 32'h10, {26'h0, service_grant});
  endtask
  // channel k on at 64k units, off after on_u[k] units
  task automatic t_start;
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(OFS_TAB + 8'(8 * k), {16'h0, 8'h80 | 8'(k), on_u[k]});
      wr_reg(OFS_TAB + 8'(8 * k + 4), {16'h0, 8'(k), 8'h40 - on_u[k]});
    end
    wr_reg(OFS_CTRL, 32'h2);
    wr_reg(OFS_CTRL, 32'h1);
    wait (run_event[0] === 1'b1);
    wr_reg(OFS_TIM, 32'h1234);
    repeat (4) @(posedge clk);
    chk("eng_param0 on", 32'h0, {16'h0, eng_param[0]});
    wait (run_event[0] === 1'b0);
    @(posedge clk);
    #1 chk("eng_load", 32'h1, {28'h0, eng_load});
    repeat (2) @(posedge clk);
    chk("eng_param0 off", 32'h1234, {16'h0, eng_param[0]});
    chk("on time", 32'd6400, t_off[0] - t_on[0]);
    rd_reg(OFS_STAT);
    chk("done flag", 32'h1, {31'h0, d[STAT_DONE]});
    rd_reg(OFS_AVG);
    chk("averages", 32'h0045_0004, d);
    wr_reg(OFS_STAT, 32'h100);
  endtask
  task automatic t_trip;
    wait (run_event[1] === 1'b1);
    repeat (2) @(posedge clk);
    chk("lag", 32'd51200, t_on[1] - t_on[0]);
    oc_req <= 4'h2;
    repeat (8) @(posedge clk);
    chk("run after trip", 32'h0, {31'h0, run_event[1]});
    chk("fault_led", 32'h1, {31'h0, fault_led});
    rd_reg(OFS_STAT);
    chk("fault and live", 32'h420, d & 32'h420);
    rd_reg(OFS_ERR);
    chk("error code", 32'h2, d);
    oc_req <= 4'h0;
    wr_reg(OFS_ERR, 32'h0);
  endtask
  task automatic t_discard;
    wait (cyc > t_on[1] + 4400);
    rd_reg(OFS_ERR);
    chk("discard code", 32'h3, d);
    rd_reg(OFS_AVG + 8'h04);
    chk("averages ch1", 32'h0, d);
    rd_reg(OFS_STAT);
    chk("done flag", 32'h0, {31'h0, d[STAT_DONE]});
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_start();
    t_trip();
    t_discard();
    finish_test();
  end
endmodule
